/* File: shared/act_pkg.sv */
/*
 * Shared definitions for the acquisition counter/timer unit: widths, selector
 * encodings, prescale timing and the carrier structs for trigger and camera events.
 * Assumes a single 50 MHz system clock and one design that imports this package.
 */
`default_nettype none
package act_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_US = 1;                       // timebase period in microseconds
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int CNT_W = 32;
	localparam int CC_BITS = 4;
	localparam int ISO_BITS = 4;
	localparam logic [ISO_BITS-1:0] ISO_OUT_MASK = 4'hC; // bits 2,3 outputs as standard
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;

	// trigger source select
	typedef enum logic [2:0] {
		ACT_TSRC_ISO0 = 3'h0,
		ACT_TSRC_ISO1 = 3'h1,
		ACT_TSRC_DIFA0 = 3'h2,
		ACT_TSRC_DIFA1 = 3'h3,
		ACT_TSRC_DIFB0 = 3'h4,
		ACT_TSRC_DIFB1 = 3'h5,
		ACT_TSRC_ASTABLE = 3'h6,
		ACT_TSRC_SOFT = 3'h7
	} act_tsrc_t;

	typedef enum logic [1:0] {
		ACT_EV_LINE = 2'h0,
		ACT_EV_FRAME = 2'h1,
		ACT_EV_US = 2'h2
	} act_event_t;

	typedef enum logic [1:0] {
		ACT_GATE_LINE = 2'h0,
		ACT_GATE_FRAME = 2'h1,
		ACT_GATE_TRIG = 2'h2,
		ACT_GATE_ACQ = 2'h3
	} act_gate_t;

	typedef enum logic [1:0] {
		ACT_OSRC_SOFT = 2'h0,
		ACT_OSRC_MONO_A = 2'h1,
		ACT_OSRC_MONO_B = 2'h2,
		ACT_OSRC_TRIG = 2'h3
	} act_osrc_t;

	typedef enum logic [1:0] {
		ACT_DLY_IDLE = 2'h0,
		ACT_DLY_WAIT = 2'h1,
		ACT_DLY_FIRE = 2'h2
	} act_dly_state_t;

	// external inputs gathered together
	typedef struct packed {
		logic [ISO_BITS-1:0] iso;
		logic [1:0] difA;
		logic [1:0] difB;
		logic lineValid;
		logic frameValid;
		logic acqActive;
	} act_inputs_t;

	// trigger conditioning configuration
	typedef struct packed {
		act_tsrc_t src;
		logic edgeMode;   // 1 = rising edge, 0 = level
		logic envelope;   // line-scan envelope mode
	} act_trig_cfg_t;
endpackage
`default_nettype wire

/* File: hdl/act_monostable.sv */
/*
 * One-shot exposure pulse generator driven by the shared microsecond tick.
 * Assumes trigger is a one-cycle pulse and period is held stable while running.
 */
`default_nettype none
module act_monostable
	import act_pkg::*;
#(
	parameter int WIDTH = CNT_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tick,
	input wire logic trigger,
	input wire logic [WIDTH-1:0] period,
	output logic pulse
);
	logic [WIDTH-1:0] remain_q, remain_d;
	logic pulse_q, pulse_d;

	// load on trigger, count down per tick, drop at zero; a zero period gives no pulse
	always_comb begin
		remain_d = remain_q;
		pulse_d = pulse_q;
		if (trigger && period != '0) begin
			remain_d = period;
			pulse_d = 1'b1;
		end else if (pulse_q && tick) begin
			if (remain_q == WIDTH'(1)) begin
				pulse_d = 1'b0;
				remain_d = '0;
			end else begin
				remain_d = remain_q - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			remain_q <= '0;
			pulse_q <= 1'b0;
		end else begin
			remain_q <= remain_d;
			pulse_q <= pulse_d;
		end
	end

	assign pulse = pulse_q;

	property p_mono_start;
		@(posedge clk) disable iff (!reset_n)
		(trigger && period != '0) |=> pulse_q && remain_q == $past(period);
	endproperty
	a_mono_start: assert property (p_mono_start) else $error("pulse did not start");

	property p_mono_end;
		@(posedge clk) disable iff (!reset_n)
		(pulse_q && tick && remain_q == WIDTH'(1) && !trigger) |=> !pulse_q;
	endproperty
	a_mono_end: assert property (p_mono_end) else $error("pulse did not end");
endmodule
`default_nettype wire

/* File: hdl/act_counter_timers.sv */
/*
 * Acquisition counter/timer unit: microsecond prescaler, astable period generator,
 * two exposure monostables, non-retriggerable trigger delay, gated event counter
 * and output routing to the camera-control and isolated output pins.
 * Assumes all inputs are synchronous to clk and configuration ports are static
 * registers held by software elsewhere.
 */
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module act_counter_timers
	import act_pkg::*;
#(
	parameter int WIDTH = CNT_W,
	parameter logic [ISO_BITS-1:0] ISO_OUT = ISO_OUT_MASK
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire act_inputs_t pins,
	input wire act_trig_cfg_t trigCfg,
	input wire logic softTrig,
	input wire logic [WIDTH-1:0] astablePeriod,
	input wire logic [WIDTH-1:0] monoPeriodA,
	input wire logic [WIDTH-1:0] monoPeriodB,
	input wire act_tsrc_t monoTrigSrc,
	input wire logic [WIDTH-1:0] delayValue,
	input wire logic delayInLines,
	input wire act_event_t eventSel,
	input wire act_gate_t gateSel,
	input wire logic [CC_BITS-1:0] ccUseTimer,
	input wire logic [CC_BITS-1:0] ccStatic,
	input wire act_osrc_t [ISO_BITS-1:0] isoOutSel,
	input wire logic [ISO_BITS-1:0] isoSoft,
	output logic astableOut,
	output logic acqTrigger,
	output logic envelopeLine,
	output logic [WIDTH-1:0] eventCount,
	output logic [WIDTH-1:0] eventLast,
	output logic [CC_BITS-1:0] ccOut,
	output logic [ISO_BITS-1:0] isoOut,
	output logic [1:0] encoderA,
	output logic [1:0] encoderB
);
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

	//////////////////////////////////////////////////////////////////////////
	// microsecond prescaler
	logic [5:0] pre_q, pre_d;
	logic tick_q, tick_d;

	// tick is a one-cycle enable; counters never see a second clock
	always_comb begin
		tick_d = (pre_q == TICK_LAST);
		pre_d = tick_d ? '0 : pre_q + 6'h01;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q <= '0;
			tick_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			tick_q <= tick_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// input conditioning: previous values for edge detection
	act_inputs_t prev_q;
	logic lineStart, frameStart;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) prev_q <= '0;
		else prev_q <= pins;
	end
	assign lineStart = pins.lineValid & ~prev_q.lineValid;
	assign frameStart = pins.frameValid & ~prev_q.frameValid;

	// select a source level; isolated output bits never act as inputs
	function automatic logic srcLevel(act_tsrc_t s, act_inputs_t p, logic ast, logic sw);
		logic [ISO_BITS-1:0] isoIn;
		isoIn = p.iso & ~ISO_OUT;
		case (s)
			ACT_TSRC_ISO0: srcLevel = isoIn[0];
			ACT_TSRC_ISO1: srcLevel = isoIn[1];
			ACT_TSRC_DIFA0: srcLevel = p.difA[0];
			ACT_TSRC_DIFA1: srcLevel = p.difA[1];
			ACT_TSRC_DIFB0: srcLevel = p.difB[0];
			ACT_TSRC_DIFB1: srcLevel = p.difB[1];
			ACT_TSRC_ASTABLE: srcLevel = ast;
			ACT_TSRC_SOFT: srcLevel = sw;
			default: srcLevel = 1'b0;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// astable period generator
	logic [WIDTH-1:0] astCnt_q, astCnt_d;
	logic astPulse_q, astPulse_d;
	always_comb begin
		astCnt_d = astCnt_q;
		astPulse_d = 1'b0;
		if (tick_q) begin
			if (astCnt_q + CNT_ONE >= astablePeriod) begin
				astCnt_d = CNT_ZERO;
				astPulse_d = (astablePeriod != CNT_ZERO);
			end else begin
				astCnt_d = astCnt_q + CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			astCnt_q <= CNT_ZERO;
			astPulse_q <= 1'b0;
		end else begin
			astCnt_q <= astCnt_d;
			astPulse_q <= astPulse_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// trigger conditioning: level or rising edge of the chosen source
	logic trigLvl, trigLvlPrev_q, trigEvent, monoTrig, monoLvlPrev_q, monoLvl;
	assign trigLvl = srcLevel(trigCfg.src, pins, astPulse_q, softTrig);
	assign monoLvl = srcLevel(monoTrigSrc, pins, astPulse_q, softTrig);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trigLvlPrev_q <= 1'b0;
			monoLvlPrev_q <= 1'b0;
		end else begin
			trigLvlPrev_q <= trigLvl;
			monoLvlPrev_q <= monoLvl;
		end
	end
	// level mode fires every cycle the source is high; the delay unit absorbs repeats only in ACT_DLY_WAIT and ACT_DLY_FIRE
	assign trigEvent = trigCfg.edgeMode ? (trigLvl & ~trigLvlPrev_q) : trigLvl;
	assign monoTrig = monoLvl & ~monoLvlPrev_q;

	//////////////////////////////////////////////////////////////////////////
	// non-retriggerable trigger delay
	act_dly_state_t dly_q, dly_d;
	logic [WIDTH-1:0] dlyCnt_q, dlyCnt_d;
	logic dlyStep;
	assign dlyStep = delayInLines ? lineStart : tick_q;
	always_comb begin
		dly_d = dly_q;
		dlyCnt_d = dlyCnt_q;
		case (dly_q)
			ACT_DLY_IDLE: begin
				if (trigEvent && !trigCfg.envelope) begin
					dlyCnt_d = delayValue;
					dly_d = (delayValue == CNT_ZERO) ? ACT_DLY_FIRE : ACT_DLY_WAIT;
				end
			end
			ACT_DLY_WAIT: begin
				// new trigger events are ignored here
				if (dlyStep) begin
					dlyCnt_d = dlyCnt_q - CNT_ONE;
					if (dlyCnt_q == CNT_ONE) dly_d = ACT_DLY_FIRE;
				end
			end
			ACT_DLY_FIRE: dly_d = ACT_DLY_IDLE;
			default: dly_d = ACT_DLY_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dly_q <= ACT_DLY_IDLE;
			dlyCnt_q <= CNT_ZERO;
		end else begin
			dly_q <= dly_d;
			dlyCnt_q <= dlyCnt_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// monostables
	logic monoA, monoB;
	act_monostable #(.WIDTH(WIDTH)) uMonoA (
		.clk(clk), .reset_n(reset_n), .tick(tick_q), .trigger(monoTrig),
		.period(monoPeriodA), .pulse(monoA)
	);
	act_monostable #(.WIDTH(WIDTH)) uMonoB (
		.clk(clk), .reset_n(reset_n), .tick(tick_q), .trigger(monoTrig),
		.period(monoPeriodB), .pulse(monoB)
	);

	//////////////////////////////////////////////////////////////////////////
	// gated event counter
	logic [WIDTH-1:0] evCnt_q, evCnt_d, evLast_q, evLast_d;
	logic evHit, gateOpen, gateClose, gateNow, gate_q;
	always_comb begin
		case (eventSel)
			ACT_EV_LINE: evHit = lineStart;
			ACT_EV_FRAME: evHit = frameStart;
			ACT_EV_US: evHit = tick_q;
			default: evHit = 1'b0;
		endcase
		case (gateSel)
			ACT_GATE_LINE: gateNow = pins.lineValid;
			ACT_GATE_FRAME: gateNow = pins.frameValid;
			ACT_GATE_TRIG: gateNow = trigLvl;
			ACT_GATE_ACQ: gateNow = pins.acqActive;
			default: gateNow = 1'b0;
		endcase
	end
	assign gateOpen = gateNow & ~gate_q;
	assign gateClose = ~gateNow & gate_q;

	// count restarts at gate open; final value captured when gate closes
	always_comb begin
		evCnt_d = evCnt_q;
		evLast_d = evLast_q;
		if (gateClose) evLast_d = evCnt_q;
		if (gateOpen) evCnt_d = evHit ? CNT_ONE : CNT_ZERO;
		else if (gateNow && evHit) evCnt_d = evCnt_q + CNT_ONE;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			evCnt_q <= CNT_ZERO;
			evLast_q <= CNT_ZERO;
			gate_q <= 1'b0;
		end else begin
			evCnt_q <= evCnt_d;
			evLast_q <= evLast_d;
			gate_q <= gateNow;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// output routing, all registered
	logic [CC_BITS-1:0] cc_d;
	logic [ISO_BITS-1:0] iso_d;
	logic acqTrig_d, env_d;
	always_comb begin
		acqTrig_d = (dly_q == ACT_DLY_FIRE);
		env_d = trigCfg.envelope & trigLvl & pins.lineValid;
		for (int i = 0; i < CC_BITS; i++) begin
			cc_d[i] = ccUseTimer[i] ? ((i % 2 == 0) ? monoA : monoB) : ccStatic[i];
		end
		for (int i = 0; i < ISO_BITS; i++) begin
			case (isoOutSel[i])
				ACT_OSRC_SOFT: iso_d[i] = isoSoft[i];
				ACT_OSRC_MONO_A: iso_d[i] = monoA;
				ACT_OSRC_MONO_B: iso_d[i] = monoB;
				ACT_OSRC_TRIG: iso_d[i] = acqTrig_d;
				default: iso_d[i] = 1'b0;
			endcase
			iso_d[i] = iso_d[i] & ISO_OUT[i];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			astableOut <= 1'b0;
			acqTrigger <= 1'b0;
			envelopeLine <= 1'b0;
			eventCount <= CNT_ZERO;
			eventLast <= CNT_ZERO;
			ccOut <= '0;
			isoOut <= '0;
			encoderA <= 2'h0;
			encoderB <= 2'h0;
		end else begin
			astableOut <= astPulse_q;
			acqTrigger <= acqTrig_d;
			envelopeLine <= env_d;
			eventCount <= evCnt_q;
			eventLast <= evLast_q;
			ccOut <= cc_d;
			isoOut <= iso_d;
			encoderA <= pins.difA;
			encoderB <= pins.difB;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	property p_tick_period;
		@(posedge clk) disable iff (!reset_n)
		tick_q |=> !tick_q [*8];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick too frequent");

	property p_delay_ignore;
		@(posedge clk) disable iff (!reset_n)
		(dly_q == ACT_DLY_WAIT && !dlyStep) |=> dly_q == ACT_DLY_WAIT && $stable(dlyCnt_q);
	endproperty
	a_delay_ignore: assert property (p_delay_ignore) else $error("delay retriggered");

	sequence s_fire;
		dly_q == ACT_DLY_FIRE;
	endsequence
	property p_delay_fire;
		@(posedge clk) disable iff (!reset_n)
		s_fire |-> ##1 acqTrigger;
	endproperty
	a_delay_fire: assert property (p_delay_fire) else $error("delayed trigger lost");

	property p_ast_period;
		@(posedge clk) disable iff (!reset_n)
		(astPulse_q && $stable(astablePeriod)) |-> astCnt_q == CNT_ZERO;
	endproperty
	a_ast_period: assert property (p_ast_period) else $error("astable wrap wrong");

	property p_ev_capture;
		@(posedge clk) disable iff (!reset_n)
		gateClose |=> evLast_q == $past(evCnt_q);
	endproperty
	a_ev_capture: assert property (p_ev_capture) else $error("final count lost");

	property p_ev_count;
		@(posedge clk) disable iff (!reset_n)
		(gateNow && gate_q && evHit) |=> evCnt_q == $past(evCnt_q) + CNT_ONE;
	endproperty
	a_ev_count: assert property (p_ev_count) else $error("event not counted");

	property p_cc_static;
		@(posedge clk) disable iff (!reset_n)
		(!ccUseTimer[0]) |=> ccOut[0] == $past(ccStatic[0]);
	endproperty
	a_cc_static: assert property (p_cc_static) else $error("static cc wrong");

	property p_iso_input_quiet;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |-> (isoOut & ~ISO_OUT) == '0;
	endproperty
	a_iso_input_quiet: assert property (p_iso_input_quiet) else $error("input bit driven");

	property p_env;
		@(posedge clk) disable iff (!reset_n)
		(trigCfg.envelope && trigLvl && pins.lineValid) |=> envelopeLine;
	endproperty
	a_env: assert property (p_env) else $error("envelope line missed");
endmodule
`default_nettype wire

/* File: test/act_cam_model.sv */
/*
 * Behavioural camera model: on a frame request it raises frame valid and sends
 * the asked number of lines, each line valid for 10 of 20 cycles.
 * Assumes the bench pulses frameReq for one cycle while no frame is running.
 */
`default_nettype none
module act_cam_model
	import act_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic frameReq,
	input wire logic [7:0] nLines,
	output logic lineValid,
	output logic frameValid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lineCnt;
	logic [4:0] phase;
	//////////////////////////////////////////////////////////////////////////////
	// line valid is driven low between lines and outside frames, as a camera does
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lineValid <= 1'b0;
			frameValid <= 1'b0;
			lineCnt <= 8'h00;
			phase <= 5'h00;
		end else if (!frameValid) begin
			lineValid <= 1'b0;
			phase <= 5'h00;
			lineCnt <= nLines;
			frameValid <= frameReq;
		end else begin
			phase <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
			lineValid <= (phase >= 5'h04) && (phase < 5'h0E) && (lineCnt != 8'h00);
			if (phase == 5'h13) begin
				lineCnt <= lineCnt - 8'h01;
				frameValid <= (lineCnt > 8'h01); // short frame ends after one period
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/act_counter_timers_tb_top.sv */
/*
 * Self-checking bench for the counter/timer unit: one task per scenario.
 * Assumes the camera model above and the hand-over latencies of the unit.
 */
`default_nettype none
`define ACT_CHECK(what, exp, got) begin nCompared++; if ((got) !== (exp)) begin \
	$display("wrong value %s expected %0h seen %0h", what, exp, got); numErrors++; end end
module act_counter_timers_tb_top
	import act_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset_n = 1'b0, softTrig = 1'b0, acqActive = 1'b0, frameReq = 1'b0;
	logic delayInLines = 1'b0, lineValid, frameValid, astableOut, acqTrigger, envelopeLine;
	logic [3:0] iso = 4'h0, ccUseTimer = 4'h0, ccStatic = 4'h0, isoSoft = 4'h0, ccOut, isoOut;
	logic [1:0] difA = 2'h0, difB = 2'h0, encoderA, encoderB;
	logic [7:0] nLines = 8'h00;
	logic [31:0] astablePeriod = 32'h0, monoPeriodA = 32'h0, monoPeriodB = 32'h0;
	logic [31:0] delayValue = 32'h0, eventCount, eventLast;
	act_inputs_t pins;
	act_trig_cfg_t trigCfg = '{src: ACT_TSRC_ISO0, edgeMode: 1'b1, envelope: 1'b0};
	act_tsrc_t monoTrigSrc = ACT_TSRC_SOFT;
	act_event_t eventSel = ACT_EV_LINE;
	act_gate_t gateSel = ACT_GATE_FRAME;
	act_osrc_t [3:0] isoOutSel = '{ACT_OSRC_TRIG, ACT_OSRC_MONO_A, ACT_OSRC_SOFT, ACT_OSRC_SOFT};
	int numErrors = 0, nCompared = 0, cycNo = 0, lvRises = 0, trigs = 0, astGap = 0;
	int astLast = 0, hiA = 0, hiB = 0, envHi = 0, envBad = 0, lat;
	logic lvPrev = 1'b0, envOn = 1'b0;
	assign pins = {iso, difA, difB, lineValid, frameValid, acqActive};
	always #10 clk = ~clk;
	act_counter_timers act_counter_timers_i (.clk(clk), .reset_n(reset_n), .pins(pins),
		.trigCfg(trigCfg), .softTrig(softTrig), .astablePeriod(astablePeriod),
		.monoPeriodA(monoPeriodA), .monoPeriodB(monoPeriodB), .monoTrigSrc(monoTrigSrc),
		.delayValue(delayValue), .delayInLines(delayInLines), .eventSel(eventSel),
		.gateSel(gateSel), .ccUseTimer(ccUseTimer), .ccStatic(ccStatic), .isoOutSel(isoOutSel),
		.isoSoft(isoSoft), .astableOut(astableOut), .acqTrigger(acqTrigger),
		.envelopeLine(envelopeLine), .eventCount(eventCount), .eventLast(eventLast),
		.ccOut(ccOut), .isoOut(isoOut), .encoderA(encoderA), .encoderB(encoderB));
	act_cam_model act_cam_model_i (.clk(clk), .reset_n(reset_n), .frameReq(frameReq),
		.nLines(nLines), .lineValid(lineValid), .frameValid(frameValid));
	//////////////////////////////////////////////////////////////////////////////
	// monitors read pre-edge values, so counts never race the design's updates
	always @(posedge clk) begin
		cycNo++;
		if (lineValid && !lvPrev) lvRises++;
		if (envOn && envelopeLine !== (iso[1] & lvPrev)) envBad++; // one cycle late
		if (envelopeLine === 1'b1) envHi++;
		lvPrev = lineValid;
		if (acqTrigger === 1'b1) trigs++;
		if (astableOut === 1'b1) begin
			astGap = cycNo - astLast;
			astLast = cycNo;
		end
		if (ccOut[0] === 1'b1) hiA++;
		if (ccOut[1] === 1'b1) hiB++;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// bounded wait for a delayed trigger, latency counted in edges
	task automatic waitTrig();
		int s;
		s = cycNo;
		for (int i = 0; i < 400 && acqTrigger !== 1'b1; i++) cyc(1);
		lat = cycNo - s;
	endtask
	task automatic frame(input logic [7:0] n);
		nLines = n;
		frameReq = 1'b1;
		cyc(1);
		frameReq = 1'b0;
		cyc(1);
		for (int i = 0; i < 400 && frameValid === 1'b1; i++) cyc(1);
		cyc(3);
	endtask
	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_astable();
		for (int p = 1; p <= 3; p += 2) begin
			astablePeriod = p;
			cyc(400);
			`ACT_CHECK("astable gap", p * 50, astGap)
		end
		trigCfg.src = ACT_TSRC_ASTABLE;
		trigs = 0;
		cyc(320);
		`ACT_CHECK("astable as trigger", 1'b1, trigs >= 2)
		astablePeriod = 0;
		trigCfg.src = ACT_TSRC_ISO0;
		cyc(10);
		$display("test astable done");
	endtask
	task automatic t_delay();
		iso[0] = 1'b1;
		waitTrig();
		`ACT_CHECK("zero delay latency", 2, lat)
		`ACT_CHECK("trigger on iso out", 1'b1, isoOut[3])
		for (int m = 1; m >= 0; m--) begin
			iso[0] = 1'b0;
			trigCfg.edgeMode = m[0];
			cyc(10);
			trigs = 0;
			iso[0] = 1'b1;
			cyc(40);
			`ACT_CHECK("level or edge", m[0], trigs == 1)
		end
		iso[0] = 1'b0;
		trigCfg.edgeMode = 1'b1;
		delayValue = 2;
		cyc(10);
		trigs = 0;
		iso[0] = 1'b1;
		cyc(20);
		iso[0] = 1'b0;
		cyc(5);
		iso[0] = 1'b1;
		waitTrig();
		`ACT_CHECK("us delay", 1'b1, lat >= 26 && lat <= 79)
		cyc(150);
		`ACT_CHECK("retrigger ignored", 1, trigs)
		iso[0] = 1'b0;
		cyc(2);
		iso[0] = 1'b1;
		waitTrig();
		`ACT_CHECK("accepted after expiry", 1'b1, acqTrigger)
		iso[0] = 1'b0;
		$display("test delay done");
	endtask
	task automatic t_lines();
		trigCfg.src = ACT_TSRC_DIFA0;
		delayInLines = 1'b1;
		delayValue = 3;
		cyc(2);
		difA = 2'h1;   // raised only once the new source has been sampled low
		lvRises = 0;
		nLines = 5;
		frameReq = 1'b1;
		cyc(1);
		frameReq = 1'b0;
		waitTrig();
		`ACT_CHECK("line delay", 3, lvRises)
		`ACT_CHECK("encoder copy", 2'h1, encoderA)
		cyc(120);
		difA = 2'h0;
		delayInLines = 1'b0;
		delayValue = 0;
		trigCfg.src = ACT_TSRC_ISO0;
		$display("test lines done");
	endtask
	task automatic t_mono();
		monoPeriodA = 2;
		monoPeriodB = 3;
		ccUseTimer = 4'h3;
		ccStatic = 4'hC;
		isoOutSel[3] = ACT_OSRC_MONO_B;
		cyc(2);
		hiA = 0;
		hiB = 0;
		softTrig = 1'b1;
		cyc(5);
		`ACT_CHECK("both pulses", 4'hF, ccOut)
		`ACT_CHECK("mono on iso out", 1'b1, isoOut[2])
		`ACT_CHECK("second mono on iso out", 1'b1, isoOut[3])
		cyc(200);
		`ACT_CHECK("width A", 1'b1, hiA >= 51 && hiA <= 100)
		`ACT_CHECK("width B", 1'b1, hiB >= 101 && hiB <= 150)
		`ACT_CHECK("after pulses", 4'hC, ccOut)
		softTrig = 1'b0;
		ccUseTimer = 4'h0;
		ccStatic = 4'h5;
		cyc(3);
		`ACT_CHECK("static levels", 4'h5, ccOut)
		$display("test mono done");
	endtask
	task automatic t_event();
		frame(4);
		`ACT_CHECK("lines per frame", 32'h4, eventLast)
		`ACT_CHECK("count held after gate", 32'h4, eventCount)
		frame(2);
		`ACT_CHECK("last count replaced", 32'h2, eventLast)
		eventSel = ACT_EV_FRAME;
		gateSel = ACT_GATE_ACQ;
		acqActive = 1'b1;
		frame(1);
		frame(1);
		acqActive = 1'b0;
		cyc(3);
		`ACT_CHECK("frames per acquisition", 32'h2, eventLast)
		eventSel = ACT_EV_US;
		gateSel = ACT_GATE_TRIG;
		trigCfg.edgeMode = 1'b0;
		iso[0] = 1'b1;
		cyc(250);
		iso[0] = 1'b0;
		cyc(3);
		`ACT_CHECK("us per trigger gate", 1'b1, eventLast >= 4 && eventLast <= 6)
		gateSel = ACT_GATE_LINE;
		frame(1);
		`ACT_CHECK("us per line", 1'b1, eventLast <= 1)
		trigCfg.edgeMode = 1'b1;
		$display("test event done");
	endtask
	task automatic t_env();
		trigCfg.envelope = 1'b1;
		trigCfg.src = ACT_TSRC_ISO1;
		iso[1] = 1'b1;
		cyc(2);
		{envOn, envBad, envHi, trigs} = {1'b1, 96'h0};
		frame(3);
		iso[1] = 1'b0;
		frame(2);
		`ACT_CHECK("envelope lines", 30, envHi)
		`ACT_CHECK("envelope follows", 0, envBad)
		`ACT_CHECK("no delayed trigger", 0, trigs)
		{envOn, trigCfg.envelope} = 2'b00;
		$display("test envelope done");
	endtask
	task automatic t_iso();
		isoOutSel = '{ACT_OSRC_SOFT, ACT_OSRC_SOFT, ACT_OSRC_SOFT, ACT_OSRC_SOFT};
		isoSoft = 4'hF;
		difA = 2'h2;
		difB = 2'h1;
		cyc(3);
		`ACT_CHECK("soft iso, inputs low", 4'hC, isoOut)
		`ACT_CHECK("encoder pair", 4'h9, {encoderA, encoderB})
		isoSoft = 4'h4;
		cyc(3);
		`ACT_CHECK("soft clear", 4'h4, isoOut)
		$display("test iso done");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// main sequence; the watchdog allows about ten times the expected run
	initial begin
		repeat (4) @(posedge clk);
		`ACT_CHECK("outputs in reset", 32'h0, {astableOut, acqTrigger, ccOut, isoOut, eventLast})
		#1 reset_n = 1'b1;
		cyc(1);
		`ACT_CHECK("outputs after reset", 32'h0, eventCount)
		t_astable();
		t_delay();
		t_lines();
		t_mono();
		t_event();
		t_env();
		t_iso();
		endOfTest();
	end
	initial begin
		#500us;
		numErrors++;
		endOfTest();
	end
endmodule
`undef ACT_CHECK
`default_nettype wire
